//--- hw/acc_fifo.sv
`timescale 1ns/1ps
module acc_fifo #(
   parameter int W = 10,
   parameter int D = 8
) (
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   // fill side
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   // drain side
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic      [W-1:0] o_out_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0]  mem [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;

   if (D < 2 || (1 << AW) != D) $error("acc_fifo: D must be a power of two, at least 2");

   wire push = i_in_valid & o_in_ready;
   wire pop  = o_out_valid & i_out_ready;

   assign o_in_ready  = (cnt_q != (AW + 1)'(D));
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data  = mem[rd_q];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_q] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_q + AW'(push);
         rd_q  <= rd_q + AW'(pop);
         cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   a_fifo_no_overflow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !o_in_ready |=> cnt_q == $past(cnt_q) || $past(pop))
      else $error("fifo count changed while full without a pop");
endmodule // acc_fifo

//--- hw/acc_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser, one bit per lane
module acc_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   if (W < 1) $error("acc_sync: W must be at least 1");

   always_ff @(posedge i_clk) begin
      meta_q <= i_d;
      sync_q <= meta_q;
   end

   assign o_q = sync_q;
endmodule // acc_sync

//--- hw/acc_top.sv
`timescale 1ns/1ps
module acc_top #(
   parameter logic [4:0] ADDR_PREFIX = 5'h0B,  // arbitrary value
   parameter int         FIFO_DEPTH  = acc_pkg::FIFO_DEPTH
) (
   // system clock and reset
   input  wire logic                      I_CLK,
   input  wire logic                      I_RESETN,
   // converter clock and comparator
   input  wire logic                      I_CONV_CLK,
   input  wire logic                      I_COMP,
   // two-wire bus
   input  wire logic                      I_SCL,
   input  wire logic                      I_SDA,
   output logic                           O_SDA,
   output logic                           O_SDA_OE,
   // address straps
   input  wire logic                      I_ADDR_PIN_LOW,
   input  wire logic                      I_ADDR_PIN_HIGH,
   // analog control
   output logic                           O_REF_ON,
   output logic                           O_ADC_PWR,
   output logic                           O_INPUT_TYPE_SEL,
   output logic [acc_pkg::CH_W-1:0]       O_CHANNEL_SEL,
   output logic [acc_pkg::RES_W-1:0]      O_SAR_CODE
);
   import acc_pkg::*;

   if (FIFO_DEPTH < 2) $error("acc_top: FIFO_DEPTH must be at least 2");

   // ---------------- system domain ----------------
   logic [4:0]        pin_s;
   acc_bus_t          bus_state_q;
   acc_bus_t          bus_state_d;
   logic [3:0]        bit_cnt_q;
   logic [3:0]        bit_cnt_d;
   logic [BYTE_W-1:0] sh_q;
   logic [BYTE_W-1:0] sh_d;
   logic              sda_oe_q;
   logic              sda_oe_d;
   logic              scl_prev_q;
   logic              sda_prev_q;
   logic              rw_q;
   logic              nack_q;
   logic              byte_idx_q;
   logic [1:0]        strap_q;
   logic              strap_done_q;
   logic [BYTE_W-1:0] cmd_q;
   logic              start_tgl_q;
   logic              ref_on_q;
   logic              ref_pend_q;
   logic [RES_W-1:0]  res_q;
   logic              res_seen_q;
   logic              push_pend_q;
   logic              ack_tgl_q;
   logic              sda_out_q;
   logic              fifo_iready;
   logic              fifo_ovalid;
   logic [RES_W-1:0]  fifo_odata;
   // conversion domain signals read by the system domain
   logic [RES_W-1:0]  res_c_q;
   logic              res_tgl_c_q;

   acc_sync #(.W(5)) u_pin_sync (
      .i_clk (I_CLK),
      .i_d   ({I_SCL, I_SDA, I_ADDR_PIN_HIGH, I_ADDR_PIN_LOW, res_tgl_c_q}),
      .o_q   (pin_s)
   );

   wire scl_s     = pin_s[4];
   wire sda_s     = pin_s[3];
   wire res_tgl_s = pin_s[0];

   // bus event decode
   wire scl_rise  = scl_s & ~scl_prev_q;
   wire scl_fall  = ~scl_s & scl_prev_q;
   wire bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   wire bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   wire bus_cond  = bus_start | bus_stop;
   wire rx_state  = (bus_state_q == BS_ADDR) | (bus_state_q == BS_CMD);
   wire rx_bit    = scl_rise & rx_state;
   wire byte_end  = scl_fall & (bit_cnt_q == BYTE_BITS);
   wire addr_hit  = (sh_q[ADR_PFX_HI:ADR_PFX_LO] == ADDR_PREFIX)
                    & (sh_q[ADR_STRAP_HI:ADR_STRAP_LO] == strap_q);  // R18
   wire addr_done = (bus_state_q == BS_ADDR) & byte_end;
   wire cmd_done  = (bus_state_q == BS_CMD) & byte_end;
   wire ack_end   = scl_fall & ((bus_state_q == BS_ADDR_ACK) | (bus_state_q == BS_CMD_ACK));
   wire tx_enter  = (bus_state_q == BS_ADDR_ACK) & scl_fall & rw_q;  // R03
   wire tx_next   = (bus_state_q == BS_TX_ACK) & scl_fall & ~nack_q;
   wire tx_load   = tx_enter | tx_next;
   wire tx_last   = (bus_state_q == BS_TX) & scl_fall & (bit_cnt_q == LAST_BIT);
   wire tx_shift  = (bus_state_q == BS_TX) & scl_fall & (bit_cnt_q != LAST_BIT);
   wire cmd_pd1   = sh_q[CMD_REF_BIT];

   // result pop and byte formation
   wire              pop    = tx_enter & fifo_ovalid;  // R04
   wire [RES_W-1:0]  tx_res = pop ? fifo_odata : res_q;
   wire [BYTE_W-1:0] byte0  = {{BYTE0_PAD{1'b0}}, tx_res[RES_W-1:RES_W-4]};  // R06
   wire [BYTE_W-1:0] byte1  = {tx_res[5:0], {BYTE1_PAD{1'b0}}};  // R06
   wire [BYTE_W-1:0] tx_byte = byte_idx_q ? byte1 : byte0;  // R05
   wire              res_edge = (res_tgl_s != res_seen_q) & ~push_pend_q;
   wire              push_ok  = push_pend_q & fifo_iready;

   always_comb begin
      bus_state_d = bus_state_q;
      if (bus_start) begin
         bus_state_d = BS_ADDR;
      end else if (bus_stop) begin
         bus_state_d = BS_IDLE;
      end else begin
         unique case (bus_state_q)
            BS_IDLE:     bus_state_d = BS_IDLE;
            BS_ADDR:     if (byte_end) bus_state_d = addr_hit ? BS_ADDR_ACK : BS_IDLE;
            BS_ADDR_ACK: if (scl_fall) bus_state_d = rw_q ? BS_TX : BS_CMD;
            BS_CMD:      if (byte_end) bus_state_d = BS_CMD_ACK;
            BS_CMD_ACK:  if (scl_fall) bus_state_d = BS_CMD;
            BS_TX:       if (tx_last) bus_state_d = BS_TX_ACK;
            BS_TX_ACK:   if (scl_fall) bus_state_d = nack_q ? BS_IDLE : BS_TX;
            default:     bus_state_d = BS_IDLE;
         endcase
      end
   end

   always_comb begin
      bit_cnt_d = bit_cnt_q;
      sh_d      = sh_q;
      sda_oe_d  = sda_oe_q;
      if (bus_cond) begin
         bit_cnt_d = '0;
         sda_oe_d  = 1'b0;
      end else if (rx_bit) begin
         bit_cnt_d = bit_cnt_q + 4'h1;
         sh_d      = {sh_q[BYTE_W-2:0], sda_s};
      end else if (addr_done) begin
         bit_cnt_d = '0;
         sda_oe_d  = addr_hit;  // R02
      end else if (cmd_done) begin
         bit_cnt_d = '0;
         sda_oe_d  = 1'b1;
      end else if (tx_load) begin
         bit_cnt_d = '0;
         sh_d      = tx_byte;
         sda_oe_d  = ~tx_byte[BYTE_W-1];
      end else if (ack_end || tx_last) begin
         sda_oe_d  = 1'b0;
      end else if (tx_shift) begin
         bit_cnt_d = bit_cnt_q + 4'h1;
         sh_d      = {sh_q[BYTE_W-2:0], 1'b0};
         sda_oe_d  = ~sh_q[BYTE_W-2];
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         bus_state_q <= BS_IDLE;
         bit_cnt_q   <= '0;
         sh_q        <= '0;
         sda_oe_q    <= 1'b0;
         scl_prev_q  <= 1'b1;
         sda_prev_q  <= 1'b1;
         sda_out_q   <= 1'b0;
      end else begin
         bus_state_q <= bus_state_d;
         bit_cnt_q   <= bit_cnt_d;
         sh_q        <= sh_d;
         sda_oe_q    <= sda_oe_d;
         scl_prev_q  <= scl_s;
         sda_prev_q  <= sda_s;
         sda_out_q   <= 1'b0;
      end
   end

   // address straps caught once after reset release
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         strap_q      <= 2'h0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         strap_q      <= pin_s[2:1];  // R18
         strap_done_q <= 1'b1;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         rw_q       <= 1'b0;
         nack_q     <= 1'b1;
         byte_idx_q <= 1'b0;
      end else begin
         if (addr_done) rw_q <= sh_q[ADR_RW_BIT];
         if (scl_rise && bus_state_q == BS_TX_ACK) nack_q <= sda_s;
         if (addr_done) byte_idx_q <= 1'b0;
         else if (tx_load) byte_idx_q <= ~byte_idx_q;  // R05
      end
   end

   // command capture, conversion start and reference sequencing
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         cmd_q       <= CMD_RST;
         start_tgl_q <= 1'b0;
         ref_on_q    <= REF_ON_RST;  // R10
         ref_pend_q  <= 1'b0;
      end else begin
         if (cmd_done) begin
            cmd_q       <= sh_q;
            start_tgl_q <= ~start_tgl_q;  // R01
         end
         if (cmd_done) begin
            ref_pend_q <= cmd_pd1 & ~ref_on_q;  // R13
            if (!cmd_pd1) ref_on_q <= 1'b0;  // R14
         end else if (bus_cond && ref_pend_q) begin
            ref_on_q   <= 1'b1;  // R13
            ref_pend_q <= 1'b0;
         end
      end
   end

   // result handover from the conversion domain into the queue
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         res_q       <= RES_RST;
         res_seen_q  <= 1'b0;
         push_pend_q <= 1'b0;
         ack_tgl_q   <= 1'b0;
      end else begin
         if (pop) res_q <= fifo_odata;  // R19
         if (res_edge) begin
            res_seen_q  <= res_tgl_s;
            push_pend_q <= 1'b1;
         end else if (push_ok) begin
            push_pend_q <= 1'b0;
            ack_tgl_q   <= ~ack_tgl_q;
         end
      end
   end

   acc_fifo #(.W(RES_W), .D(FIFO_DEPTH)) u_fifo (
      .i_clk       (I_CLK),
      .i_rst_n     (I_RESETN),
      .i_in_valid  (push_pend_q),
      .o_in_ready  (fifo_iready),
      .i_in_data   (res_c_q),
      .o_out_valid (fifo_ovalid),
      .i_out_ready (pop),
      .o_out_data  (fifo_odata)
   );

   assign O_SDA    = sda_out_q;
   assign O_SDA_OE = sda_oe_q;
   assign O_REF_ON = ref_on_q;

   // ---------------- conversion domain ----------------
   logic [2:0]        cs;
   acc_conv_t         cv_state_q;
   acc_conv_t         cv_state_d;
   logic              start_seen_q;
   logic [RES_W-1:0]  mask_q;
   logic [RES_W-1:0]  code_q;
   logic [WAKE_W-1:0] wake_cnt_q;
   logic [CH_W-1:0]   chan_q;
   logic              se_q;
   logic              pd0_q;
   logic              pwr_q;

   acc_sync #(.W(3)) u_conv_sync (
      .i_clk (I_CONV_CLK),
      .i_d   ({I_RESETN, start_tgl_q, ack_tgl_q}),
      .o_q   (cs)
   );

   wire rst_c_n = cs[2];
   wire start_s = cs[1];
   wire ack_s   = cs[0];
   wire go_c    = (cv_state_q == CV_IDLE) & (start_s != start_seen_q);
   wire sar_end = (cv_state_q == CV_CONV) & mask_q[0];
   wire [RES_W-1:0] code_nx = (I_COMP ? code_q : (code_q & ~mask_q)) | (mask_q >> 1);

   always_comb begin
      cv_state_d = cv_state_q;
      unique case (cv_state_q)
         CV_IDLE: if (go_c) cv_state_d = pd0_q ? CV_CONV : CV_WAKE;  // R09
         CV_WAKE: if (wake_cnt_q == '0) cv_state_d = CV_CONV;
         CV_CONV: if (mask_q[0]) cv_state_d = CV_HAND;
         CV_HAND: if (ack_s == res_tgl_c_q) cv_state_d = CV_IDLE;
      endcase
   end

   always_ff @(posedge I_CONV_CLK) begin
      if (!rst_c_n) begin
         cv_state_q   <= CV_IDLE;
         start_seen_q <= 1'b0;
         pwr_q        <= 1'b0;
      end else begin
         cv_state_q   <= cv_state_d;
         if (go_c) start_seen_q <= start_s;
         pwr_q        <= (cv_state_d != CV_IDLE) | pd0_q;  // R16
      end
   end

   always_ff @(posedge I_CONV_CLK) begin
      if (!rst_c_n) begin
         chan_q     <= '0;
         se_q       <= 1'b0;
         pd0_q      <= 1'b0;
         wake_cnt_q <= '0;
         mask_q     <= '0;
         code_q     <= RES_RST;
      end else if (go_c) begin
         chan_q     <= cmd_q[CMD_CH_HI:CMD_CH_LO];
         se_q       <= cmd_q[CMD_SE_BIT];  // R17
         pd0_q      <= cmd_q[CMD_CONV_BIT];  // R16
         wake_cnt_q <= WAKE_W'(PWRUP_CYC - 1);  // R09
         mask_q     <= SAR_MSB;
         code_q     <= SAR_MSB;
      end else if (cv_state_q == CV_WAKE) begin
         wake_cnt_q <= wake_cnt_q - 1'b1;
      end else if (cv_state_q == CV_CONV) begin
         mask_q     <= mask_q >> 1;
         code_q     <= code_nx;
      end
   end

   always_ff @(posedge I_CONV_CLK) begin
      if (!rst_c_n) begin
         res_c_q     <= RES_RST;
         res_tgl_c_q <= 1'b0;
      end else if (sar_end) begin
         res_c_q     <= code_nx;  // R19
         res_tgl_c_q <= ~res_tgl_c_q;
      end
   end

   assign O_ADC_PWR        = pwr_q;
   assign O_INPUT_TYPE_SEL = se_q;
   assign O_CHANNEL_SEL    = chan_q;
   assign O_SAR_CODE       = code_q;

   // ---------------- checks ----------------
   sequence s_read_open;
      (bus_state_q == BS_ADDR_ACK) && scl_fall && rw_q && !bus_cond;
   endsequence

   sequence s_second_byte;
      tx_next && byte_idx_q && !bus_cond;
   endsequence

   a_addr_ack: assert property (@(posedge I_CLK) disable iff (!I_RESETN)  // R02
      addr_done && addr_hit |=> sda_oe_q && bus_state_q == BS_ADDR_ACK)
      else $error("matching address not acknowledged");

   a_addr_miss: assert property (@(posedge I_CLK) disable iff (!I_RESETN)  // R18
      addr_done && !addr_hit |=> !sda_oe_q && bus_state_q == BS_IDLE)
      else $error("non-matching address was acknowledged");

   a_byte0_pad: assert property (@(posedge I_CLK) disable iff (!I_RESETN)  // R06
      s_read_open |=> sh_q[7:4] == 4'h0 && byte_idx_q)
      else $error("first result byte has nonzero upper bits");

   a_byte1_pad: assert property (@(posedge I_CLK) disable iff (!I_RESETN)  // R06
      s_second_byte |=> sh_q[1:0] == 2'h0 && sh_q[7:2] == $past(tx_res[5:0]))
      else $error("second result byte malformed");

   a_ref_wait: assert property (@(posedge I_CLK) disable iff (!I_RESETN)  // R13
      cmd_done && cmd_pd1 && !ref_on_q |=> !ref_on_q && ref_pend_q)
      else $error("reference switched on at the command byte");

   a_ref_turn_on: assert property (@(posedge I_CLK) disable iff (!I_RESETN)  // R13
      ref_pend_q && bus_cond && !cmd_done |=> ref_on_q)
      else $error("reference not on after stop or repeated start");

   a_ref_off: assert property (@(posedge I_CLK) disable iff (!I_RESETN)  // R14
      cmd_done && !cmd_pd1 |=> !ref_on_q ##1 !ref_on_q || $past(ref_pend_q))
      else $error("reference not turned off by command");

   a_start_conv: assert property (@(posedge I_CLK) disable iff (!I_RESETN)  // R01
      cmd_done |=> start_tgl_q != $past(start_tgl_q))
      else $error("command byte did not start a conversion");

   a_result_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)  // R19
      !pop |=> res_q == $past(res_q))
      else $error("held result changed without a read");

   a_wake_len: assert property (@(posedge I_CONV_CLK) disable iff (!rst_c_n)  // R09
      go_c && !pd0_q |=> cv_state_q == CV_WAKE && wake_cnt_q == WAKE_W'(PWRUP_CYC - 1))
      else $error("power-up wait not started with full count");

   a_input_type: assert property (@(posedge I_CONV_CLK) disable iff (!rst_c_n)  // R17
      go_c |=> se_q == $past(cmd_q[CMD_SE_BIT]) && pwr_q)
      else $error("input type or converter power not applied at start");
endmodule // acc_top

//--- pkg/acc_pkg.sv
// What this block does, and what the bus master is expected to do
// R01 - after a write address, a command byte powers the converter and starts a conversion
// R02 - acknowledge in the ninth clock after an address byte that matches
// R03 - master reads results by addressing with the direction bit set to 1
// R04 - a read returns a valid result only after a command started a conversion
// R05 - each result goes out as two bytes, upper byte first
// R06 - byte 0 is four zeros then bits 9..6; byte 1 is bits 5..0 then two zeros
// R07 - master should issue repeated start after each read for continuous conversions
// R08 - master should not clock data for 3.7 us after a repeated start
// R09 - converter powers up after command, fully up within 1.4 us
// R10 - internal reference is off after power on
// R11 - master keeps reference power bit at 1 while using the internal reference
// R12 - master waits settling time after turning the reference back on
// R13 - an off reference turns on only at the stop or repeated start after the command
// R14 - reference on: bit 1 keeps it on; any command with bit 0 turns it off
// R15 - with an external reference master sends reference power bit 0
// R16 - power bits: 00 down between conversions, 01 converter only, 10 ref only, 11 both
// R17 - input type bit: 0 differential pairs, 1 single-ended against common
// R18 - address is fixed prefix, two strapped bits, then direction bit
// R19 - latest result is held until shifted out or replaced; the code queues unread results and a read returns the oldest one
package acc_pkg;
   localparam int RES_W         = 10;
   localparam int BYTE_W        = 8;
   localparam int CH_W          = 3;
   localparam int PFX_W         = 5;
   // command byte layout
   localparam int CMD_SE_BIT    = 7;
   localparam int CMD_CH_HI     = 6;
   localparam int CMD_CH_LO     = 4;
   localparam int CMD_REF_BIT   = 3;
   localparam int CMD_CONV_BIT  = 2;
   // address byte layout
   localparam int ADR_PFX_HI    = 7;
   localparam int ADR_PFX_LO    = 3;
   localparam int ADR_STRAP_HI  = 2;
   localparam int ADR_STRAP_LO  = 1;
   localparam int ADR_RW_BIT    = 0;
   // result byte padding
   localparam int BYTE0_PAD     = 4;
   localparam int BYTE1_PAD     = 2;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // converter power-up time, counted on the conversion clock
   localparam int PWRUP_NS      = 1400;
   localparam int CONV_CLK_PS   = 48000;
   localparam int PWRUP_CYC     = (PWRUP_NS * 1000 + CONV_CLK_PS - 1) / CONV_CLK_PS;
   localparam int WAKE_W        = $clog2(PWRUP_CYC + 1);
   localparam int FIFO_DEPTH    = 8;
   // reset values
   localparam logic             REF_ON_RST = 1'b0;
   localparam logic [RES_W-1:0] RES_RST    = 10'h000;
   localparam logic [RES_W-1:0] SAR_MSB    = 10'h200;
   localparam logic [BYTE_W-1:0] CMD_RST   = 8'h00;

   typedef enum logic [2:0] {
      BS_IDLE, BS_ADDR, BS_ADDR_ACK, BS_CMD, BS_CMD_ACK, BS_TX, BS_TX_ACK
   } acc_bus_t;

   typedef enum logic [1:0] {CV_IDLE, CV_WAKE, CV_CONV, CV_HAND} acc_conv_t;
endpackage

//--- sim/acc_bus_model.sv
`timescale 1ns/1ps
// two-wire bus master; open-drain data, changes only at the system clock's falling edge
module acc_bus_model #(
   parameter int H = 20
) (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   task automatic hw(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   // data moves a few cycles after scl falls, never with it
   task automatic clk_bit(output logic b);
      hw(H);
      o_scl = 1'b1;
      hw(H);
      b = i_sda;
      o_scl = 1'b0;
      hw(4);
   endtask

   task automatic start();
      o_sda = 1'b1;
      hw(H);
      o_scl = 1'b1;
      hw(H);
      o_sda = 1'b0;
      hw(H);
      o_scl = 1'b0;
      hw(4);
   endtask

   task automatic stop();
      o_sda = 1'b0;
      hw(H);
      o_scl = 1'b1;
      hw(H);
      o_sda = 1'b1;
      hw(H);
   endtask

   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int k = 7; k >= 0; k--) begin
         o_sda = b[k];
         clk_bit(s);
      end
      o_sda = 1'b1;
      clk_bit(s);
      ack = ~s;
   endtask

   task automatic rbyte(output logic [7:0] b, input logic ack);
      logic s;
      o_sda = 1'b1;
      for (int k = 7; k >= 0; k--) begin
         clk_bit(s);
         b[k] = s;
      end
      o_sda = ~ack;
      clk_bit(s);
      o_sda = 1'b1;
   endtask
endmodule // acc_bus_model

//--- sim/acc_top_tb.sv
`timescale 1ns/1ps
module acc_top_tb;
   import acc_pkg::*;
   localparam logic [4:0] PFX = 5'h11; // arbitrary value
   logic        clk      = 1'b0;
   logic        conv_clk = 1'b0;
   logic        rst_n    = 1'b0;
   logic        a_lo;
   logic        a_hi;
   logic [9:0]  vin      = 10'h000;
   logic        sda_m;
   logic        scl;
   logic        oe;
   logic        osda;
   logic        ref_on;
   logic        adc_pwr;
   logic        se;
   logic [2:0]  ch;
   logic [9:0]  sar;
   wire logic   sda_w;
   wire logic   comp;
   int          err_total  = 0;
   int          num_checks = 0;
   int          cyc        = 0;
   logic        aa;
   logic        ca;
   logic        ref_exp;
   logic [7:0]  cmd;
   logic [15:0] d;
   logic [9:0]  q[$];

   always #2.5 clk = ~clk;
   initial begin
      #1.3;
      forever #24 conv_clk = ~conv_clk;
   end
   // pulled-up wire; analog input compared with the trial code
   assign sda_w = sda_m & (~oe | osda);
   assign comp  = (vin >= sar);

   acc_top #(.ADDR_PREFIX(PFX), .FIFO_DEPTH(FIFO_DEPTH)) i_acc_top (
      .I_CLK(clk), .I_RESETN(rst_n), .I_CONV_CLK(conv_clk), .I_COMP(comp),
      .I_SCL(scl), .I_SDA(sda_w), .O_SDA(osda), .O_SDA_OE(oe),
      .I_ADDR_PIN_LOW(a_lo), .I_ADDR_PIN_HIGH(a_hi), .O_REF_ON(ref_on),
      .O_ADC_PWR(adc_pwr), .O_INPUT_TYPE_SEL(se), .O_CHANNEL_SEL(ch), .O_SAR_CODE(sar));
   acc_bus_model #(.H(20)) i_acc_bus_model (
      .i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_m));

   function automatic logic [15:0] f_bytes(input logic [9:0] v);
      return {4'h0, v[9:6], v[5:0], 2'b00};
   endfunction

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] c, output logic xa, output logic xc);
      i_acc_bus_model.start();
      i_acc_bus_model.wbyte(a, xa);
      i_acc_bus_model.wbyte(c, xc);
   endtask

   task automatic rd(output logic [15:0] r, output logic xa);
      i_acc_bus_model.start();
      i_acc_bus_model.wbyte({PFX, a_hi, a_lo, 1'b1}, xa);
      i_acc_bus_model.rbyte(r[15:8], 1'b1);
      i_acc_bus_model.rbyte(r[7:0], 1'b0);
      // keep the bus with a repeated start, then stay quiet for 3.7 us
      i_acc_bus_model.start();
      repeat (740) @(negedge clk);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         err_total++;
         end_sim();
      end
   end

   initial begin
      void'($urandom(949));
      a_lo = 1'($urandom);
      a_hi = 1'($urandom);
      // converter domain sees reset through its synchroniser
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (20) @(negedge clk);
      chk_bit("ref_reset", 1'b0, ref_on);
      rd(d, aa);
      chk_bit("read_addr_ack", 1'b1, aa);
      chk("read_empty", 16'h0, d);
      wr({~PFX, a_hi, a_lo, 1'b0}, 8'h0C, aa, ca);
      i_acc_bus_model.stop();
      repeat (20) @(negedge clk);
      chk_bit("bad_addr_ack", 1'b0, aa);
      chk_bit("bad_addr_ref", 1'b0, ref_on);
      ref_exp = 1'b0;
      for (int i = 0; i < 9; i++) begin
         cmd = 8'($urandom);
         // steps with reference bit 0 stand for an external reference
         cmd[3:2] = 2'(i);
         vin = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($urandom);
         q.push_back(vin);
         wr({PFX, a_hi, a_lo, 1'b0}, cmd, aa, ca);
         chk_bit("addr_ack", 1'b1, aa);
         chk_bit("cmd_ack", 1'b1, ca);
         if (!cmd[3])
            ref_exp = 1'b0;
         chk_bit("ref_before_stop", ref_exp, ref_on);
         // repeated start must switch the reference as a stop does
         if (i[1]) begin
            i_acc_bus_model.start();
            chk_bit("ref_after_sr", cmd[3], ref_on);
         end
         i_acc_bus_model.stop();
         repeat (20) @(negedge clk);
         ref_exp = cmd[3];
         chk_bit("ref_after_stop", ref_exp, ref_on);
         repeat (800) @(negedge clk);
         chk("input_sel", {12'h0, cmd[7:4]}, {12'h0, se, ch});
         if (i < 8)
            chk_bit("adc_pwr", cmd[2], adc_pwr);
      end
      // queue is full here; the last conversion waits for the first pop
      for (int i = 0; i < 10; i++) begin
         rd(d, aa);
         chk("read_data", f_bytes(q[(i < 9) ? i : 8]), d);
         repeat (800) @(negedge clk);
      end
      end_sim();
   end
endmodule // acc_top_tb
